// File: core/unl_nvm_caps_pages.sv
// user nonvolatile page and tunable laser capability page
// assumes the two-wire slave delivers one byte request per cycle, last marks a stop
//
// Notes on behaviour
// [R1] user page present raises its support advertisement output.
// [R2] user page holds 128 freely readable and writable bytes at 128-255.
// [R3] host writes at most eight bytes per transaction to the user page.
// [R4] after a user page write all accesses refused until internal write ends.
// [R5] capability page present raises its support advertisement output.
// [R6] one capability set serves the whole module and every lane.
// [R7] capability layout: grids, fine tuning, ranges, reserved bytes.
// [R8] byte 255 holds low eight bits of sum of bytes 128-254.
// [R9] channel numbers are signed 16-bit offsets from the grid anchor.
// [R10] grid byte bit 7 reports 75 GHz grid support.
// [R11] grid byte bit 6 reports 33 GHz grid support.
// [R12] grid byte bit 5 reports 100 GHz grid support.
// [R13] grid byte bit 4 reports 50 GHz grid support.
// [R14] range bytes 130-161 give lowest and highest channel per grid.
// [R15] byte 129 advertises fine tuning support.
// [R16] host writes to the capability page are ignored.
`timescale 1ns/100ps
module unl_nvm_caps_pages
    import unl_pkg::*;
#(
    parameter bit USER_PAGE_EN = 1'b1,
    parameter bit CAPS_PAGE_EN = 1'b1,
    parameter bit GRID_75G_CAPABLE = 1'b0,
    parameter bit GRID_33G_CAPABLE = 1'b0,
    parameter bit GRID_100G_CAPABLE = 1'b1,
    parameter bit GRID_50G_CAPABLE = 1'b1,
    parameter logic [3:0] GRID_FINE_BITS = 4'h0,
    parameter bit FINE_TUNE_CAPABLE = 1'b0,
    parameter bit GRID_150G_CAPABLE = 1'b0,
    parameter logic [UNL_RANGE_WORDS*16-1:0] GRID_RANGES = '0,
    parameter int NONVOLATILE_WRITE_TIME_US = 10000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire unl_req_s req,
    output unl_rsp_s rsp_q,
    output logic nvm_busy_q,
    output logic user_page_supported_q,
    output logic caps_page_supported_q
);
    localparam int NV_WRITE_CYCLES = NONVOLATILE_WRITE_TIME_US * UNL_CLK_MHZ;
    localparam int CW = $clog2(NV_WRITE_CYCLES + 1);
    localparam int WCW = $clog2(UNL_MAX_WRITE_BYTES + 1);
    localparam int AW = $clog2(UNL_USER_BYTES);

    // =====================================================================
    // capability contents, fixed at build time
    function automatic logic [7:0] cap_byte(input int idx);
        int a;
        int w;
        logic [15:0] word;
        a = idx + UNL_UPPER_BASE;
        w = 0;
        word = '0;
        cap_byte = '0;
        if (a == int'(UNL_CAP_GRID))
        begin
            cap_byte[UNL_BIT_75G] = GRID_75G_CAPABLE; // [R10]
            cap_byte[UNL_BIT_33G] = GRID_33G_CAPABLE; // [R11]
            cap_byte[UNL_BIT_100G] = GRID_100G_CAPABLE; // [R12]
            cap_byte[UNL_BIT_50G] = GRID_50G_CAPABLE; // [R13]
            cap_byte[3:0] = GRID_FINE_BITS;
        end
        else if (a == int'(UNL_CAP_FINE))
        begin
            cap_byte[UNL_BIT_FINE] = FINE_TUNE_CAPABLE; // [R15]
            cap_byte[UNL_BIT_150G] = GRID_150G_CAPABLE;
        end
        else if (a >= int'(UNL_CAP_RANGE_FIRST) && a <= int'(UNL_CAP_RANGE_LAST))
        begin
            // signed channel words, high byte at the lower address
            w = (a - int'(UNL_CAP_RANGE_FIRST)) / 2;
            word = GRID_RANGES[w*16 +: 16]; // [R14] [R9]
            cap_byte = ((a - int'(UNL_CAP_RANGE_FIRST)) % 2 == 0) ? word[15:8] : word[7:0];
        end
    endfunction

    logic [7:0] cap_rom [UNL_USER_BYTES];
    logic [7:0] cap_sum;

    // one table for the whole module, no per lane copies
    generate
        for (genvar i = 0; i < UNL_USER_BYTES; i++)
        begin : g_cap
            assign cap_rom[i] = cap_byte(i); // [R6] [R7]
        end
    endgenerate

    always_comb
    begin
        cap_sum = '0;
        for (int i = 0; i <= int'(UNL_CAP_SUM_LAST) - UNL_UPPER_BASE; i++)
        begin
            cap_sum = cap_sum + cap_rom[i]; // [R8]
        end
    end

    // =====================================================================
    // request stage
    logic user_hit;
    logic caps_hit;
    logic take_ok;
    logic mem_we;
    logic v1_q, v1_d;
    logic ref1_q, ref1_d;
    unl_req_s req1_q, req1_d;
    logic [7:0] mem_rdata;

    always_comb
    begin
        user_hit = USER_PAGE_EN && req.page == UNL_PAGE_USER && req.addr[UNL_UPPER_BIT];
        caps_hit = CAPS_PAGE_EN && req.page == UNL_PAGE_CAPS && req.addr[UNL_UPPER_BIT];
        take_ok = req_valid && !nvm_busy_q; // [R4]
        v1_d = req_valid;
        ref1_d = req_valid && nvm_busy_q; // [R4]
        req1_d = req;
    end

    // =====================================================================
    // write transaction tracking and hold-off timer
    logic [WCW-1:0] wcnt_q, wcnt_d;
    logic wrote_q, wrote_d;
    logic [CW-1:0] hold_q, hold_d;
    logic busy_d;

    always_comb
    begin
        // bytes past the eighth are dropped rather than wrapping the page
        mem_we = take_ok && req.we && user_hit && wcnt_q < WCW'(UNL_MAX_WRITE_BYTES); // [R3] [R2]
        wcnt_d = wcnt_q;
        wrote_d = wrote_q;
        hold_d = hold_q;
        busy_d = nvm_busy_q;
        if (take_ok && req.we && user_hit && !req.last && wcnt_q < WCW'(UNL_MAX_WRITE_BYTES))
        begin
            wcnt_d = wcnt_q + WCW'(1);
        end
        if (mem_we)
        begin
            wrote_d = 1'b1;
        end
        if (take_ok && req.last)
        begin
            wcnt_d = '0;
            wrote_d = 1'b0;
            if (wrote_q || mem_we)
            begin
                busy_d = 1'b1; // [R4]
                hold_d = CW'(NV_WRITE_CYCLES - 1);
            end
        end
        else if (nvm_busy_q)
        begin
            // ends within the nonvolatile write time limit
            if (hold_q == '0)
            begin
                busy_d = 1'b0; // [R4]
            end
            else
            begin
                hold_d = hold_q - CW'(1);
            end
        end
    end

    unl_user_nvm_ram #(
        .DEPTH(UNL_USER_BYTES),
        .AW(AW)
    ) u_ram (
        .clk(clk),
        .we(mem_we),
        .waddr(req.addr[AW-1:0]),
        .wdata(req.wdata),
        .raddr(req.addr[AW-1:0]),
        .rdata_q(mem_rdata)
    );

    // =====================================================================
    // answer stage
    unl_rsp_s rsp_d;
    logic user1;
    logic caps1;

    always_comb
    begin
        user1 = USER_PAGE_EN && req1_q.page == UNL_PAGE_USER && req1_q.addr[UNL_UPPER_BIT];
        caps1 = CAPS_PAGE_EN && req1_q.page == UNL_PAGE_CAPS && req1_q.addr[UNL_UPPER_BIT];
        rsp_d.ack = v1_q && !ref1_q;
        rsp_d.refused = v1_q && ref1_q; // [R4]
        rsp_d.rdata = '0;
        if (v1_q && !ref1_q && !req1_q.we)
        begin
            if (user1)
            begin
                rsp_d.rdata = mem_rdata; // [R2]
            end
            else if (caps1)
            begin
                // writes to this page never reach storage, reads stay fixed
                rsp_d.rdata = (req1_q.addr == UNL_CAP_CHECKSUM) ? cap_sum
                                                               : cap_rom[req1_q.addr[AW-1:0]]; // [R16] [R8]
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            v1_q <= 1'b0;
            ref1_q <= 1'b0;
            req1_q <= '0;
            wcnt_q <= '0;
            wrote_q <= 1'b0;
            hold_q <= '0;
            nvm_busy_q <= 1'b0;
            rsp_q <= '0;
            user_page_supported_q <= 1'b0;
            caps_page_supported_q <= 1'b0;
        end
        else
        begin
            v1_q <= v1_d;
            ref1_q <= ref1_d;
            req1_q <= req1_d;
            wcnt_q <= wcnt_d;
            wrote_q <= wrote_d;
            hold_q <= hold_d;
            nvm_busy_q <= busy_d;
            rsp_q <= rsp_d;
            user_page_supported_q <= USER_PAGE_EN; // [R1]
            caps_page_supported_q <= CAPS_PAGE_EN; // [R5]
        end
    end
endmodule

// File: common/unl_pkg.sv
// constants and carriers for the user nonvolatile page and laser capability page
// assumes a byte access port fed by the module's two-wire slave front end
package unl_pkg;
    // =====================================================================
    // page and byte addresses
    localparam logic [7:0] UNL_PAGE_USER = 8'h03;
    localparam logic [7:0] UNL_PAGE_CAPS = 8'h04;
    localparam logic [7:0] UNL_CAP_GRID = 8'h80;
    localparam logic [7:0] UNL_CAP_FINE = 8'h81;
    localparam logic [7:0] UNL_CAP_RANGE_FIRST = 8'h82;
    localparam logic [7:0] UNL_CAP_RANGE_LAST = 8'ha1;
    localparam logic [7:0] UNL_CAP_SUM_LAST = 8'hfe;
    localparam logic [7:0] UNL_CAP_CHECKSUM = 8'hff;
    localparam int UNL_UPPER_BIT = 7;
    // =====================================================================
    // field positions
    localparam int UNL_BIT_75G = 7;
    localparam int UNL_BIT_33G = 6;
    localparam int UNL_BIT_100G = 5;
    localparam int UNL_BIT_50G = 4;
    localparam int UNL_BIT_FINE = 7;
    localparam int UNL_BIT_150G = 6;
    // =====================================================================
    // sizes and timing
    localparam int UNL_USER_BYTES = 128;
    localparam int UNL_UPPER_BASE = 128;
    localparam int UNL_MAX_WRITE_BYTES = 8;
    localparam int UNL_RANGE_WORDS = 16;
    localparam int UNL_CLK_MHZ = 100;
    // =====================================================================
    // carriers
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic last;
    } unl_req_s;
    typedef struct packed {
        logic ack;
        logic refused;
        logic [7:0] rdata;
    } unl_rsp_s;
endpackage

// File: core/unl_user_nvm_ram.sv
// byte memory backing the user nonvolatile page
// assumes one write and one read port on the same clock, read data registered
`timescale 1ns/100ps
module unl_user_nvm_ram #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [DEPTH];

    // =====================================================================
    // storage, contents survive reset as a nonvolatile array would
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule

// File: tb/unl_host_model.sv
// host controller model issuing single byte requests
// assumes answers come two rising edges after a request is taken
`timescale 1ns/100ps
module unl_host_model
    import unl_pkg::*;
(
    input wire logic clk,
    input wire unl_rsp_s rsp_q,
    output unl_req_s req,
    output logic req_valid
);
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end
    // ==========================================
    // one try: drive at falling edge, sample the answer in the one cycle it stands
    task automatic try_once(input unl_req_s r, output unl_rsp_s a);
        @(negedge clk);
        req_valid = 1'b1;
        req = r;
        @(negedge clk);
        req_valid = 1'b0;
        req = ~r; // released lines must not keep the last value
        @(negedge clk);
        a = rsp_q;
    endtask
    // bounded retry, so a stuck hold-off shows up
    task automatic access(input unl_req_s r, output unl_rsp_s a, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            try_once(r, a);
            ok = a.ack;
        end
    endtask
endmodule

// File: tb/unl_pages_assertions.sv
// checker for the nvm and capability page block
// sees only the top module ports, bound at the foot
`timescale 1ns/100ps
module unl_pages_assertions
    import unl_pkg::*;
#(
    parameter bit USER_PAGE_EN = 1'b1,
    parameter bit CAPS_PAGE_EN = 1'b1,
    parameter logic [7:0] GRID_BYTE = 8'h00,
    parameter int NONVOLATILE_WRITE_TIME_US = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire unl_req_s req,
    input wire unl_rsp_s rsp_q,
    input wire logic nvm_busy_q,
    input wire logic user_page_supported_q,
    input wire logic caps_page_supported_q
);
    localparam int NV_CYCLES = NONVOLATILE_WRITE_TIME_US * UNL_CLK_MHZ;
    int busy_run_q;
    int busy_run_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // length of the current hold-off
    always_comb busy_run_d = nvm_busy_q ? busy_run_q + 1 : 0;
    always_ff @(posedge clk) busy_run_q <= reset_n ? busy_run_d : 0;
    sequence s_take_idle;
        req_valid && !nvm_busy_q;
    endsequence
    sequence s_user_stop;
        req.we && req.last && req.page == UNL_PAGE_USER && req.addr[UNL_UPPER_BIT];
    endsequence
    a_single_answer:
        assert property (req_valid |-> ##2 (rsp_q.ack ^ rsp_q.refused)) else $error("no single answer");
    a_refuse_busy:
        assert property (req_valid && nvm_busy_q |-> ##2 rsp_q.refused && rsp_q.rdata == 8'h00)
        else $error("busy request not refused");
    a_accept_idle:
        assert property (s_take_idle |-> ##2 rsp_q.ack) else $error("idle request not acked");
    a_busy_after_write:
        assert property (s_take_idle ##0 s_user_stop |=> nvm_busy_q) else $error("no hold-off");
    a_busy_exact:
        assert property ($fell(nvm_busy_q) |-> busy_run_q == NV_CYCLES) else $error("hold-off length");
    a_busy_bounded:
        assert property (busy_run_q <= NV_CYCLES) else $error("hold-off too long");
    a_grid_byte:
        assert property (s_take_idle ##0 (!req.we && req.page == UNL_PAGE_CAPS
            && req.addr == UNL_CAP_GRID) |-> ##2 rsp_q.rdata == GRID_BYTE) else $error("grid byte");
    a_support_flags:
        assert property ($past(reset_n) |-> user_page_supported_q == USER_PAGE_EN
            && caps_page_supported_q == CAPS_PAGE_EN) else $error("support flags");
    a_quiet_idle:
        assert property (!$past(req_valid, 2) |-> !(rsp_q.ack || rsp_q.refused))
        else $error("answer without request");
endmodule
bind unl_nvm_caps_pages unl_pages_assertions #(.USER_PAGE_EN(USER_PAGE_EN),
    .CAPS_PAGE_EN(CAPS_PAGE_EN), .NONVOLATILE_WRITE_TIME_US(NONVOLATILE_WRITE_TIME_US),
    .GRID_BYTE({GRID_75G_CAPABLE, GRID_33G_CAPABLE, GRID_100G_CAPABLE, GRID_50G_CAPABLE,
    GRID_FINE_BITS})) chk (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .rsp_q(rsp_q), .nvm_busy_q(nvm_busy_q), .user_page_supported_q(user_page_supported_q),
    .caps_page_supported_q(caps_page_supported_q));

// File: tb/unl_nvm_caps_pages_test.sv
// self-checking bench for the nvm and capability page block
// assumes the host model drives all requests
`timescale 1ns/100ps
module unl_nvm_caps_pages_test
    import unl_pkg::*;
();
    localparam logic [7:0] GRID_BYTE = 8'ha5;
    localparam logic [255:0] RANGES = {4{64'h0123456789abcdef}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid;
    unl_req_s req;
    unl_rsp_s rsp_q;
    logic nvm_busy_q;
    logic user_sup;
    logic caps_sup;
    int mismatches = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    // grid flags taken from the expected grid byte so stimulus and expectation agree
    unl_nvm_caps_pages #(.GRID_75G_CAPABLE(GRID_BYTE[7]), .GRID_33G_CAPABLE(GRID_BYTE[6]),
        .GRID_100G_CAPABLE(GRID_BYTE[5]), .GRID_50G_CAPABLE(GRID_BYTE[4]),
        .GRID_FINE_BITS(GRID_BYTE[3:0]), .FINE_TUNE_CAPABLE(1'b1), .GRID_RANGES(RANGES),
        .NONVOLATILE_WRITE_TIME_US(1)) dut (
        .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .rsp_q(rsp_q),
        .nvm_busy_q(nvm_busy_q), .user_page_supported_q(user_sup), .caps_page_supported_q(caps_sup));
    unl_host_model host (.clk(clk), .rsp_q(rsp_q), .req(req), .req_valid(req_valid));
    // ==========================================
    // expected capability bytes, range words high byte first
    function automatic logic [7:0] exp_cap(input int a);
        logic [15:0] w;
        w = (a >= 130 && a < 162) ? RANGES[(a - 130) / 2 * 16 +: 16] : 16'h0000;
        if (a == 128) return GRID_BYTE;
        if (a == 129) return 8'h80;
        return a[0] ? w[7:0] : w[15:8];
    endfunction
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] wd,
        input logic we, input logic last, output logic [7:0] rd);
        unl_rsp_s a;
        bit ok;
        host.access('{pg, ad, wd, we, last}, a, ok);
        rd = a.rdata;
        if (!ok)
        begin
            mismatches++;
            $display("CHECK FAILED hold-off expected ack seen none");
            test_done();
        end
    endtask
    // ==========================================
    initial
    begin
        logic [7:0] d;
        logic [7:0] sum;
        unl_rsp_s a;
        sum = 8'h00;
        for (int i = 128; i < 255; i++)
            sum += exp_cap(i);
        repeat (13) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        check8("support flags", 8'h03, {6'h00, user_sup, caps_sup});
        for (int i = 128; i < 162; i++)
        begin
            xfer(UNL_PAGE_CAPS, i[7:0], 8'h00, 1'b0, 1'b1, d);
            check8("cap byte", exp_cap(i), d);
        end
        xfer(UNL_PAGE_CAPS, 8'hca, 8'h00, 1'b0, 1'b1, d);
        check8("reserved byte", 8'h00, d);
        xfer(UNL_PAGE_CAPS, UNL_CAP_CHECKSUM, 8'h00, 1'b0, 1'b1, d);
        check8("checksum", sum, d);
        xfer(UNL_PAGE_CAPS, UNL_CAP_GRID, 8'h00, 1'b1, 1'b1, d);
        xfer(UNL_PAGE_CAPS, UNL_CAP_GRID, 8'h00, 1'b0, 1'b1, d);
        check8("grid after write", GRID_BYTE, d);
        $display("test caps page done");
        for (int i = 0; i < UNL_MAX_WRITE_BYTES; i++)
            xfer(UNL_PAGE_USER, 8'hf8 + i[7:0], 8'h3c ^ i[7:0], 1'b1, i == 7, d);
        host.try_once('{UNL_PAGE_USER, 8'hf8, 8'h00, 1'b0, 1'b1}, a);
        check8("hold-off answer", 8'h01, {6'h00, a.ack, a.refused});
        for (int i = 0; i < UNL_MAX_WRITE_BYTES; i++)
        begin
            xfer(UNL_PAGE_USER, 8'hf8 + i[7:0], 8'h00, 1'b0, 1'b1, d);
            check8("user byte", 8'h3c ^ i[7:0], d);
        end
        $display("test user page done");
        test_done();
    end
endmodule
